/* File: include/dbcl_map.vh */
// Summary of operation
// - Checks start after exit delay, clock enable high twice
// - Idle after precharge recovery delay elapses, or from reset once device ready
// - Active after row-to-column delay, nothing pending
// - Reading lasts until non-autoprecharge read burst ends
// - Writing lasts until non-autoprecharge write burst ends
// - Register accesses return to a state set by their start context after delay
// - Read/write rules cover both autoprecharge variants
// - Register read accepted while target bank idle, activating, active or precharging
// - Bank after register read follows its own state
// - Device reset is a special register write
// - Write mask high blocks beat, low writes it
// - Precharge to idle bank still waits recovery delay
`ifndef DBCL_MAP_VH
`define DBCL_MAP_VH
`define DBCL_CMD_NOP 4'h0
`define DBCL_CMD_ACT 4'h1
`define DBCL_CMD_RD 4'h2
`define DBCL_CMD_WR 4'h3
`define DBCL_CMD_PRE 4'h4
`define DBCL_CMD_PREA 4'h5
`define DBCL_CMD_REF 4'h6
`define DBCL_CMD_SREF 4'h7
`define DBCL_CMD_MRR 4'h8
`define DBCL_CMD_MRW 4'h9
`define DBCL_CMD_RESET 4'ha
`define DBCL_CMD_PDX 4'hb
`define DBCL_CMD_SRX 4'hc
`define DBCL_ST_IDLE 3'h0
`define DBCL_ST_ROWACT 3'h1
`define DBCL_ST_ACTIVE 3'h2
`define DBCL_ST_READ 3'h3
`define DBCL_ST_WRITE 3'h4
`define DBCL_ST_PRECH 3'h5
`define DBCL_ST_RESET 3'h6
`define DBCL_T_RCD 8'h04
`define DBCL_T_RP 8'h04
`define DBCL_T_RRD 8'h02
`define DBCL_T_MRR 8'h04
`define DBCL_T_MRW 8'h0a
`define DBCL_T_XSR 8'h20
`define DBCL_T_XP 8'h04
`define DBCL_T_BURST 8'h04
`endif

/* File: design/dbcl_timer.v */
`timescale 1ns/1ns
`include "dbcl_map.vh"
// Down counter: load starts a delay, done when zero
module dbcl_timer #(
    parameter W = 8
) (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // Control
    input wire load_in,
    input wire [W-1:0] value_in,
    // Status
    output wire done_out
);
    reg [W-1:0] count;
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= {W{1'b0}};
        end else if (load_in) begin
            count <= value_in;
        end else if (count != {W{1'b0}}) begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
        end
    end
    assign done_out = (count == {W{1'b0}});
endmodule

/* File: design/dbcl_bank.v */
`timescale 1ns/1ns
`include "dbcl_map.vh"
// One bank's state with its own delay timer
module dbcl_bank (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // Command for this bank, already accepted
    input wire act_in,
    input wire rd_in,
    input wire wr_in,
    input wire ap_in,
    input wire pre_in,
    input wire dev_reset_in,
    input wire dev_ready_in,
    // State
    output reg [2:0] state_out,
    output reg ap_pend_out
);
    reg load;
    reg [7:0] value;
    wire done;
    dbcl_timer #(.W(8)) u_tmr (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .load_in(load),
        .value_in(value),
        .done_out(done)
    );
    // Autoprecharge must still sit out the full recovery delay
    wire auto_pre = ap_pend_out && done && (state_out == `DBCL_ST_READ || state_out == `DBCL_ST_WRITE);
    always @* begin
        load = act_in | rd_in | wr_in | pre_in | auto_pre;
        value = `DBCL_T_BURST;
        if (act_in) begin
            value = `DBCL_T_RCD;
        end else if (pre_in || (auto_pre && !rd_in && !wr_in)) begin
            value = `DBCL_T_RP;
        end
    end
    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_out <= `DBCL_ST_RESET;
            ap_pend_out <= 1'b0;
        end else if (dev_reset_in) begin
            state_out <= `DBCL_ST_RESET;
            ap_pend_out <= 1'b0;
        end else if (act_in) begin
            state_out <= `DBCL_ST_ROWACT;
        end else if (rd_in) begin
            state_out <= `DBCL_ST_READ;
            ap_pend_out <= ap_in;
        end else if (wr_in) begin
            state_out <= `DBCL_ST_WRITE;
            ap_pend_out <= ap_in;
        end else if (pre_in) begin
            state_out <= `DBCL_ST_PRECH;
            // An explicit precharge supersedes a pending autoprecharge
            ap_pend_out <= 1'b0;
        end else begin
            case (state_out)
                `DBCL_ST_RESET: if (dev_ready_in) state_out <= `DBCL_ST_IDLE;
                `DBCL_ST_ROWACT: if (done) state_out <= `DBCL_ST_ACTIVE;
                `DBCL_ST_PRECH: if (done) state_out <= `DBCL_ST_IDLE;
                `DBCL_ST_READ, `DBCL_ST_WRITE: begin
                    // Autoprecharge bursts roll straight into recovery
                    if (done && ap_pend_out) begin
                        state_out <= `DBCL_ST_PRECH;
                        ap_pend_out <= 1'b0;
                    end else if (done) begin
                        state_out <= `DBCL_ST_ACTIVE;
                    end
                end
                default: state_out <= state_out;
            endcase
        end
    end
endmodule

/* File: design/dbcl_core.v */
`timescale 1ns/1ns
`include "dbcl_map.vh"
// Bank state tracking and cross-bank command legality checker
module dbcl_core #(
    parameter NB = 8
) (
    // Clock and reset
    input wire core_clk_in,
    input wire rst_in,
    // Command bus
    input wire cke_in,
    input wire [3:0] cmd_in,
    input wire [2:0] bank_in,
    input wire ap_in,
    input wire all_in,
    // Write data path
    input wire wdata_valid_in,
    input wire write_mask_input_in,
    // Results
    output reg cmd_accept_out,
    output reg cmd_illegal_out,
    output reg beat_write_out,
    output reg ready_out,
    output reg busy_mr_out,
    output reg [3*NB-1:0] bank_state_out
);
    localparam M_NONE = 2'h0;
    localparam M_IDLE = 2'h1;
    localparam M_RST = 2'h2;
    localparam M_ACT = 2'h3;

    wire [3*NB-1:0] st;
    wire [NB-1:0] append;
    reg cke_q;
    reg exit_wait;
    reg dev_ready;
    reg [1:0] mr_kind;
    reg mr_load;
    reg [7:0] mr_val;
    wire mr_done;
    reg rrd_load;
    wire rrd_done;
    reg ex_load;
    reg [7:0] ex_val;
    wire ex_done;
    reg legal;
    reg all_idle;
    reg any_rd;
    reg any_wr;
    reg pre_ok;
    reg [2:0] tgt;
    reg dev_reset;
    integer i;
    wire cmd_accept_now;

    dbcl_timer #(.W(8)) u_mr (
        .core_clk_in(core_clk_in), .rst_in(rst_in),
        .load_in(mr_load), .value_in(mr_val), .done_out(mr_done)
    );
    dbcl_timer #(.W(8)) u_rrd (
        .core_clk_in(core_clk_in), .rst_in(rst_in),
        .load_in(rrd_load), .value_in(`DBCL_T_RRD), .done_out(rrd_done)
    );
    dbcl_timer #(.W(8)) u_ex (
        .core_clk_in(core_clk_in), .rst_in(rst_in),
        .load_in(ex_load), .value_in(ex_val), .done_out(ex_done)
    );

    // Per-bank trackers, one generate entry per bank
    genvar g;
    generate
        for (g = 0; g < NB; g = g + 1) begin : bk
            wire hit = (bank_in == g) | all_in;
            wire ok = cmd_accept_now;
            dbcl_bank u_bank (
                .core_clk_in(core_clk_in),
                .rst_in(rst_in),
                .act_in(ok && cmd_in == `DBCL_CMD_ACT && bank_in == g),
                .rd_in(ok && cmd_in == `DBCL_CMD_RD && bank_in == g),
                .wr_in(ok && cmd_in == `DBCL_CMD_WR && bank_in == g),
                .ap_in(ap_in),
                .pre_in(ok && ((cmd_in == `DBCL_CMD_PRE && hit) || cmd_in == `DBCL_CMD_PREA)),
                .dev_reset_in(dev_reset),
                .dev_ready_in(dev_ready),
                .state_out(st[3*g+2:3*g]),
                .ap_pend_out(append[g])
            );
        end
    endgenerate

    wire mr_busy = (mr_kind != M_NONE);
    wire checks_on = cke_q & cke_in & ~exit_wait;
    assign cmd_accept_now = legal & (cmd_in != `DBCL_CMD_NOP);

    always @* begin
        all_idle = 1'b1;
        any_rd = 1'b0;
        any_wr = 1'b0;
        pre_ok = 1'b1;
        tgt = st[3*bank_in +: 3];
        for (i = 0; i < NB; i = i + 1) begin
            if (st[3*i +: 3] != `DBCL_ST_IDLE) all_idle = 1'b0;
            if (st[3*i +: 3] == `DBCL_ST_READ && i != bank_in) any_rd = 1'b1;
            if (st[3*i +: 3] == `DBCL_ST_WRITE && i != bank_in) any_wr = 1'b1;
            if (st[3*i +: 3] == `DBCL_ST_RESET || st[3*i +: 3] == `DBCL_ST_ROWACT) pre_ok = 1'b0;
        end
        legal = 1'b0;
        if (checks_on && !mr_busy) begin
            case (cmd_in)
                `DBCL_CMD_NOP: legal = 1'b1;
                `DBCL_CMD_ACT: legal = dev_ready && tgt == `DBCL_ST_IDLE && rrd_done;
                `DBCL_CMD_RD: legal = (tgt == `DBCL_ST_ACTIVE || tgt == `DBCL_ST_READ) && !any_wr
                    && !append[bank_in];
                `DBCL_CMD_WR: legal = (tgt == `DBCL_ST_ACTIVE || tgt == `DBCL_ST_WRITE) && !any_rd
                    && !append[bank_in];
                `DBCL_CMD_PRE: legal = all_in ? pre_ok : (tgt != `DBCL_ST_RESET && tgt != `DBCL_ST_ROWACT);
                `DBCL_CMD_PREA: legal = pre_ok;
                `DBCL_CMD_REF, `DBCL_CMD_SREF: legal = all_idle;
                // A register write before the device is ready brings it out of reset once its delay ends
                `DBCL_CMD_MRW: legal = all_idle | ~dev_ready;
                `DBCL_CMD_RESET: legal = all_idle | ~dev_ready;
                `DBCL_CMD_MRR: legal = ~dev_ready || tgt == `DBCL_ST_IDLE || tgt == `DBCL_ST_ROWACT
                    || tgt == `DBCL_ST_PRECH || tgt == `DBCL_ST_ACTIVE;
                default: legal = 1'b0;
            endcase
        end else if (mr_busy) begin
            legal = (cmd_in == `DBCL_CMD_NOP);
        end else begin
            legal = (cmd_in == `DBCL_CMD_NOP) || (cmd_in == `DBCL_CMD_PDX) || (cmd_in == `DBCL_CMD_SRX);
        end
        if (!checks_on && !mr_busy && (cmd_in == `DBCL_CMD_PDX || cmd_in == `DBCL_CMD_SRX)) begin
            legal = 1'b1;
        end
    end

    always @* begin
        mr_load = 1'b0;
        mr_val = `DBCL_T_MRR;
        rrd_load = cmd_accept_now && cmd_in == `DBCL_CMD_ACT;
        ex_load = 1'b0;
        ex_val = `DBCL_T_XP;
        dev_reset = cmd_accept_now && cmd_in == `DBCL_CMD_RESET;
        if (cmd_accept_now && cmd_in == `DBCL_CMD_MRR) begin
            mr_load = 1'b1;
        end
        if (cmd_accept_now && (cmd_in == `DBCL_CMD_MRW || cmd_in == `DBCL_CMD_RESET)) begin
            mr_load = 1'b1;
            mr_val = `DBCL_T_MRW;
        end
        if (legal && cmd_in == `DBCL_CMD_PDX) begin
            ex_load = 1'b1;
        end
        if (legal && cmd_in == `DBCL_CMD_SRX) begin
            ex_load = 1'b1;
            ex_val = `DBCL_T_XSR;
        end
    end

    always @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cke_q <= 1'b0;
            exit_wait <= 1'b0;
            dev_ready <= 1'b0;
            mr_kind <= M_NONE;
            cmd_accept_out <= 1'b0;
            cmd_illegal_out <= 1'b0;
            beat_write_out <= 1'b0;
            ready_out <= 1'b0;
            busy_mr_out <= 1'b0;
            bank_state_out <= {(3*NB){1'b0}};
        end else begin
            cke_q <= cke_in;
            if (ex_load) begin
                exit_wait <= 1'b1;
            end else if (ex_done) begin
                exit_wait <= 1'b0;
            end
            // return state follows the start context
            if (mr_busy && mr_done && !mr_load) begin
                if (mr_kind == M_IDLE) begin
                    dev_ready <= 1'b1;
                end
                mr_kind <= M_NONE;
            end
            if (mr_load) begin
                if (cmd_in == `DBCL_CMD_RESET) begin
                    mr_kind <= M_RST;
                end else if (cmd_in == `DBCL_CMD_MRW) begin
                    mr_kind <= M_IDLE;
                end else if (!dev_ready) begin
                    mr_kind <= M_RST;
                end else if (tgt == `DBCL_ST_ACTIVE) begin
                    mr_kind <= M_ACT;
                end else begin
                    mr_kind <= M_IDLE;
                end
            end
            if (dev_reset) begin
                dev_ready <= 1'b0;
            end
            cmd_accept_out <= cmd_accept_now;
            cmd_illegal_out <= ~legal;
            beat_write_out <= wdata_valid_in & ~write_mask_input_in;
            ready_out <= dev_ready;
            busy_mr_out <= mr_busy;
            bank_state_out <= st;
        end
    end
endmodule

/* File: tb/dbcl_core_props.sv */
`timescale 1ns/1ns
`include "dbcl_map.vh"
module dbcl_props #(
    parameter NB = 8
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire cke_in,
    input wire [3:0] cmd_in,
    input wire [2:0] bank_in,
    input wire ap_in,
    input wire all_in,
    input wire wdata_valid_in,
    input wire write_mask_input_in,
    input wire cmd_accept_out,
    input wire cmd_illegal_out,
    input wire beat_write_out,
    input wire ready_out,
    input wire busy_mr_out,
    input wire [3*NB-1:0] bank_state_out
);
    logic rd_any, wr_any, all_idle;
    always_comb begin
        rd_any = 1'b0;
        wr_any = 1'b0;
        all_idle = 1'b1;
        for (int i = 0; i < NB; i++) begin
            rd_any = rd_any | (bank_state_out[3*i+:3] == `DBCL_ST_READ);
            wr_any = wr_any | (bank_state_out[3*i+:3] == `DBCL_ST_WRITE);
            all_idle = all_idle & (bank_state_out[3*i+:3] == `DBCL_ST_IDLE);
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    AST_ONE_VERDICT: assert property (!(cmd_accept_out && cmd_illegal_out)) else $error("accept and illegal together");
    AST_CKE_LOW: assert property (!cke_in |=> !cmd_accept_out) else $error("command taken with clock enable low");
    AST_MRW_HOLD: assert property (cmd_accept_out && $past(cmd_in) == `DBCL_CMD_MRW |=> busy_mr_out [*8])
        else $error("register write wait too short");
    AST_MRR_END: assert property (cmd_accept_out && $past(cmd_in) == `DBCL_CMD_MRR |-> ##[1:6] !busy_mr_out)
        else $error("register read wait does not end");
    AST_READY_CAUSE: assert property ($rose(ready_out) |-> $past(busy_mr_out)) else $error("ready without register write");
    AST_BEAT: assert property (wdata_valid_in |=> beat_write_out == !$past(write_mask_input_in))
        else $error("beat mask wrong");
    AST_ACT_GAP: assert property (cmd_accept_out && $past(cmd_in) == `DBCL_CMD_ACT
        |=> !(cmd_accept_out && $past(cmd_in) == `DBCL_CMD_ACT)) else $error("activates too close");
    // Bank states on the port lag the command by one cycle, so they are read one cycle later
    AST_WR_IN_RD: assert property (cmd_in == `DBCL_CMD_WR ##1 rd_any |-> !cmd_accept_out)
        else $error("write during read");
    AST_RD_IN_WR: assert property (cmd_in == `DBCL_CMD_RD ##1 wr_any |-> !cmd_accept_out)
        else $error("read during write");
    AST_REF_IDLE: assert property (cmd_in == `DBCL_CMD_REF ##1 !all_idle |-> !cmd_accept_out)
        else $error("refresh not idle");
    COV_MRW: cover property (cmd_accept_out && $past(cmd_in) == `DBCL_CMD_MRW);
    COV_ILL: cover property (cmd_illegal_out);
    COV_BEAT: cover property (beat_write_out);
endmodule
bind dbcl_core dbcl_props #(.NB(NB)) u_props (.core_clk_in(core_clk_in), .rst_in(rst_in), .cke_in(cke_in),
    .cmd_in(cmd_in), .bank_in(bank_in), .ap_in(ap_in), .all_in(all_in), .wdata_valid_in(wdata_valid_in),
    .write_mask_input_in(write_mask_input_in), .cmd_accept_out(cmd_accept_out), .cmd_illegal_out(cmd_illegal_out),
    .beat_write_out(beat_write_out), .ready_out(ready_out), .busy_mr_out(busy_mr_out),
    .bank_state_out(bank_state_out));

/* File: tb/dbcl_ctrl_model.sv */
`timescale 1ns/1ns
`include "dbcl_map.vh"
module dbcl_ctrl_model (
    // Requests from the bench
    input wire logic req_in,
    input wire logic [3:0] req_cmd_in,
    // Command bus to the device
    output logic [3:0] cmd_out
);
    // Idle cycles carry a defined no-operation, never a stale code
    assign cmd_out = req_in ? req_cmd_in : `DBCL_CMD_NOP;
endmodule

/* File: tb/test_dbcl_core.sv */
`timescale 1ns/1ns
`include "dbcl_map.vh"
module test_dbcl_core;
    logic clk = 0, rst = 1, cke = 1, req = 0, ap = 0, al = 0, wv = 0, wm = 0;
    logic [3:0] rc = 0;
    logic [2:0] bank = 0;
    wire [3:0] cmd;
    wire acc, ill, bw, rdy, bsy;
    wire [23:0] bst;
    int mismatches = 0, checks_done = 0, cyc = 0, i;
    always #4 clk = ~clk;
    dbcl_ctrl_model u_ctrl (.req_in(req), .req_cmd_in(rc), .cmd_out(cmd));
    dbcl_core #(.NB(8)) DUT (.core_clk_in(clk), .rst_in(rst), .cke_in(cke), .cmd_in(cmd), .bank_in(bank),
        .ap_in(ap), .all_in(al), .wdata_valid_in(wv), .write_mask_input_in(wm), .cmd_accept_out(acc),
        .cmd_illegal_out(ill), .beat_write_out(bw), .ready_out(rdy), .busy_mr_out(bsy), .bank_state_out(bst));
    task summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task issue(input logic [3:0] c, input logic [2:0] b, input logic a, input logic l);
        @(posedge clk);
        req <= (c != `DBCL_CMD_NOP);
        rc <= c;
        bank <= b;
        ap <= a;
        al <= l;
    endtask
    // One command, a no-operation behind it, then the verdict
    task op(input logic [3:0] c, input logic [2:0] b, input logic a, input logic l, input logic e);
        issue(c, b, a, l);
        issue(`DBCL_CMD_NOP, 0, 0, 0);
        #1;
        chk(acc, e);
        chk(ill, !e);
    endtask
    task t_init;
        #1 chk(bst, {8{`DBCL_ST_RESET}});
        op(`DBCL_CMD_MRR, 0, 0, 0, 1);
        repeat (6) @(posedge clk);
        #1 chk(bst, {8{`DBCL_ST_RESET}});
        op(`DBCL_CMD_ACT, 0, 0, 0, 0);
        op(`DBCL_CMD_MRW, 0, 0, 0, 1);
        op(`DBCL_CMD_ACT, 0, 0, 0, 0);
        chk(bsy, 1);
        for (i = 0; i < 30 && rdy !== 1'b1; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1 chk(rdy, 1);
        chk(bst, 0);
    endtask
    task t_act;
        issue(`DBCL_CMD_ACT, 0, 0, 0);
        issue(`DBCL_CMD_ACT, 1, 0, 0);
        #1 chk(acc, 1);
        issue(`DBCL_CMD_NOP, 0, 0, 0);
        #1 chk(ill, 1);
        op(`DBCL_CMD_ACT, 1, 0, 0, 1);
        op(`DBCL_CMD_MRR, 1, 0, 0, 1);
        repeat (8) @(posedge clk);
        #1 chk(bst[5:0], {`DBCL_ST_ACTIVE, `DBCL_ST_ACTIVE});
    endtask
    task t_rw;
        op(`DBCL_CMD_RD, 0, 0, 0, 1);
        op(`DBCL_CMD_WR, 1, 0, 0, 0);
        repeat (6) @(posedge clk);
        #1 chk(bst[2:0], `DBCL_ST_ACTIVE);
        op(`DBCL_CMD_WR, 1, 0, 0, 1);
        op(`DBCL_CMD_RD, 0, 0, 0, 0);
        repeat (6) @(posedge clk);
        #1 chk(bst[5:3], `DBCL_ST_ACTIVE);
        op(`DBCL_CMD_RD, 0, 1, 0, 1);
        repeat (14) @(posedge clk);
        #1 chk(bst[2:0], `DBCL_ST_IDLE);
    endtask
    task t_pre;
        op(`DBCL_CMD_REF, 0, 0, 0, 0);
        op(`DBCL_CMD_PRE, 0, 0, 0, 1);
        op(`DBCL_CMD_PRE, 0, 0, 1, 1);
        chk(bst[2:0], `DBCL_ST_PRECH);
        repeat (8) @(posedge clk);
        #1 chk(bst, 0);
        op(`DBCL_CMD_REF, 0, 0, 0, 1);
        repeat (4) @(posedge clk);
        op(`DBCL_CMD_MRR, 0, 0, 0, 1);
        op(`DBCL_CMD_ACT, 2, 0, 0, 0);
        repeat (6) @(posedge clk);
        #1 chk(bst, 0);
    endtask
    task t_mask;
        @(posedge clk);
        wv <= 1;
        wm <= 0;
        @(posedge clk);
        wm <= 1;
        #1 chk(bw, 1);
        @(posedge clk);
        wv <= 0;
        #1 chk(bw, 0);
    endtask
    task t_cke;
        @(posedge clk);
        cke <= 0;
        req <= 1;
        rc <= `DBCL_CMD_ACT;
        bank <= 2;
        @(posedge clk);
        cke <= 1;
        rc <= `DBCL_CMD_PDX;
        #1 chk(acc, 0);
        chk(ill, 1);
        @(posedge clk);
        rc <= `DBCL_CMD_ACT;
        #1 chk(acc, 1);
        @(posedge clk);
        req <= 0;
        #1 chk(acc, 0);
        repeat (4) @(posedge clk);
        op(`DBCL_CMD_ACT, 2, 0, 0, 1);
    endtask
    task t_reset;
        op(`DBCL_CMD_RESET, 0, 0, 0, 0);
        op(`DBCL_CMD_PREA, 0, 0, 0, 0);
        repeat (2) @(posedge clk);
        op(`DBCL_CMD_PREA, 0, 0, 0, 1);
        repeat (6) @(posedge clk);
        op(`DBCL_CMD_RESET, 0, 0, 0, 1);
        repeat (12) @(posedge clk);
        #1 chk(rdy, 0);
        chk(bst, {8{`DBCL_ST_RESET}});
        op(`DBCL_CMD_SREF, 0, 0, 0, 0);
    endtask
    // A hang must still reach the verdict
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            summarize;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        t_init;
        t_act;
        t_rw;
        t_pre;
        t_mask;
        t_cke;
        t_reset;
        summarize;
    end
endmodule
